//--- common/vsp_pkg.sv
// Constants shared by the setpoint and ceiling register bank
package vsp_pkg;
    localparam int          WORD_W         = 16;
    localparam int          SETPOINT_W     = 12;
    localparam int          CEILING_W      = 13;
    localparam int          RATIO_W        = 3;
    localparam int          SYNC_STAGES    = 3;

    // Command codes on the host word port
    localparam logic [7:0]  CMD_SAVE_ALL   = 8'h11;
    localparam logic [7:0]  CMD_SETPOINT   = 8'h21;
    localparam logic [7:0]  CMD_CEILING    = 8'h24;

    localparam logic [15:0] SETPOINT_RESET = 16'h01e6;
    localparam logic [15:0] SETPOINT_MASK  = 16'h0fff;
    localparam logic [15:0] CEILING_MASK   = 16'h1fff;
    localparam logic [15:0] READ_UNMAPPED  = 16'h0000;

    // Divider ratio mantissas, LSB worth one quarter
    localparam logic [2:0]  RATIO_ONE      = 3'h4;
    localparam logic [2:0]  RATIO_HALF     = 3'h2;
    localparam logic [2:0]  RATIO_QUARTER  = 3'h1;

    // Setpoint valid ranges per ratio
    localparam logic [15:0] SP_MIN_ONE     = 16'h0100;
    localparam logic [15:0] SP_MAX_ONE     = 16'h0300;
    localparam logic [15:0] SP_MIN_HALF    = 16'h0200;
    localparam logic [15:0] SP_MAX_HALF    = 16'h0600;
    localparam logic [15:0] SP_MIN_QUARTER = 16'h0400;
    localparam logic [15:0] SP_MAX_QUARTER = 16'h0c00;

    // Ceiling least values per ratio; highest equals the setpoint maximum
    localparam logic [15:0] CL_MIN_ONE     = 16'h011a;
    localparam logic [15:0] CL_MIN_HALF    = 16'h0234;
    localparam logic [15:0] CL_MIN_QUARTER = 16'h0468;

    // Cycles after reset before the strap is trusted
    localparam logic [3:0]  SETTLE_CYCLES  = 4'h6;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_LOAD   = 2'b01,
        ST_RUN    = 2'b10
    } init_state_t;
endpackage

//--- common/range_if.sv
// Divider ratio in, valid ranges out
interface range_if;
    logic [2:0]  ratio;
    logic [15:0] sp_min;
    logic [15:0] sp_max;
    logic [15:0] cl_min;
    logic [15:0] cl_max;

    modport lookup
    (
        input  ratio,
        output sp_min,
        output sp_max,
        output cl_min,
        output cl_max
    );
    modport user
    (
        output ratio,
        input  sp_min,
        input  sp_max,
        input  cl_min,
        input  cl_max
    );
endinterface

//--- core/range_lookup.sv
// Valid setpoint and ceiling ranges for the feedback divider ratio
module range_lookup
(
    range_if.lookup rng
);
    always_comb
    begin
        unique case (rng.ratio)
            vsp_pkg::RATIO_HALF:
            begin
                rng.sp_min = vsp_pkg::SP_MIN_HALF;
                rng.sp_max = vsp_pkg::SP_MAX_HALF;
                rng.cl_min = vsp_pkg::CL_MIN_HALF;
            end
            vsp_pkg::RATIO_QUARTER:
            begin
                rng.sp_min = vsp_pkg::SP_MIN_QUARTER;
                rng.sp_max = vsp_pkg::SP_MAX_QUARTER;
                rng.cl_min = vsp_pkg::CL_MIN_QUARTER;
            end
            // Unit ratio, and any illegal code falls back to it
            default:
            begin
                rng.sp_min = vsp_pkg::SP_MIN_ONE;
                rng.sp_max = vsp_pkg::SP_MAX_ONE;
                rng.cl_min = vsp_pkg::CL_MIN_ONE;
            end
        endcase
        rng.cl_max = rng.sp_max;
    end
endmodule

//--- core/pin_sync.sv
// Three-stage pin synchroniser, output follows once stages two and three agree
module pin_sync
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] level_next;

    always_comb
    begin
        level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_reg <= '0;
        end
        else
        begin
            s1_reg    <= pin;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule

//--- core/setpoint_limit_checker.sv
// Output-voltage setpoint and ceiling registers with write-time validation
// How it works
// - Setpoint is unsigned mantissa, two to minus nine volts per count.
// - Setpoint valid range follows divider ratio: 256-768, 512-1536, 1024-3072.
// - Setpoint write below floor or above ceiling loads the violated limit.
// - Setpoint write not strictly between warning thresholds leaves register unchanged.
// - Warning-threshold violation sets comms fault, invalid data, and alert.
// - Strap selection loads decoded strap mantissa at power-up, overriding restore.
// - Setpoint defaults to 486; upper four bits read zero, not writable.
// - Save-all command hands current setpoint to nonvolatile storage.
// - Ceiling bounds both programmed setpoint and strap default.
// - Write above ceiling clamps and sets misc, output-warning, ceiling-hit, alert.
// - Ceiling write out of range yet above setpoint loads highest allowed.
// - Ceiling write in range but below setpoint keeps old ceiling.
// - Either bad ceiling write sets comms fault, invalid data, alert.
// - Ceiling is mantissa two to minus nine; top three bits read-only.
// - Ratio one: ceiling 282 to 768, default 768.
// - Ratio half: ceiling 564 to 1536, default 1536.
// - Ratio quarter: ceiling 1128 to 3072, default 3072.
module setpoint_limit_checker
(
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic [15:0] WR_DATA,
    input  wire logic        WR_STROBE,
    input  wire logic        RD_STROBE,
    output logic      [15:0] RD_DATA,
    output logic             RD_VALID,
    input  wire logic [15:0] SETPOINT_FLOOR,
    input  wire logic [15:0] OVERVOLTAGE_WARNING_THRESHOLD,
    input  wire logic [15:0] UNDERVOLTAGE_WARNING_THRESHOLD,
    input  wire logic [2:0]  FEEDBACK_DIVIDER_RATIO,
    input  wire logic        STRAP_SELECT,
    input  wire logic [11:0] STRAP_SETPOINT_PIN,
    input  wire logic        NVM_RESTORE,
    input  wire logic [15:0] NVM_RESTORE_DATA,
    output logic             NVM_SAVE,
    output logic      [15:0] NVM_SAVE_SETPOINT,
    output logic      [15:0] NVM_SAVE_CEILING,
    input  wire logic        CLEAR_FLAGS,
    output logic             COMMS_FAULT_FLAG,
    output logic             INVALID_DATA_FLAG,
    output logic             MISCELLANEOUS_FAULT_FLAG,
    output logic             OUTPUT_VOLTAGE_FAULT_WARNING_FLAG,
    output logic             CEILING_HIT_WARNING,
    input  wire logic        SMBALERT_I,
    output logic             SMBALERT_O,
    output logic             SMBALERT_OE,
    output logic      [15:0] SETPOINT
);
    range_if rng ();

    range_lookup u_range
    (
        .rng (rng)
    );

    logic        strap_sel;
    logic [11:0] strap_val;

    pin_sync #(.W(1)) u_sync_sel
    (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .pin   (STRAP_SELECT),
        .level (strap_sel)
    );

    pin_sync #(.W(vsp_pkg::SETPOINT_W)) u_sync_val
    (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .pin   (STRAP_SETPOINT_PIN),
        .level (strap_val)
    );

    // Divider ratio comes from a register on this clock: no synchroniser
    assign rng.ratio = FEEDBACK_DIVIDER_RATIO;

    vsp_pkg::init_state_t state_reg;
    vsp_pkg::init_state_t state_next;
    logic [3:0]           settle_reg;
    logic [3:0]           settle_next;

    logic [15:0] setpoint_reg;
    logic [15:0] setpoint_next;
    logic [15:0] ceiling_reg;
    logic [15:0] ceiling_next;

    logic        cml_reg;
    logic        cml_next;
    logic        ivd_reg;
    logic        ivd_next;
    logic        oth_reg;
    logic        oth_next;
    logic        vfw_reg;
    logic        vfw_next;
    logic        chit_reg;
    logic        chit_next;

    logic [15:0] rd_data_reg;
    logic [15:0] rd_data_next;
    logic        rd_valid_reg;
    logic        rd_valid_next;
    logic        save_reg;
    logic        save_next;
    logic [15:0] save_sp_reg;
    logic [15:0] save_sp_next;
    logic [15:0] save_cl_reg;
    logic [15:0] save_cl_next;

    logic        run;
    logic        wr_setpoint;
    logic        wr_ceiling;
    logic        wr_save;
    logic [15:0] sp_word;
    logic [15:0] cl_word;
    logic [15:0] strap_word;
    logic        sp_warn_bad;
    logic        sp_range_bad;
    logic        sp_below_floor;
    logic        sp_above_ceiling;
    logic        cl_in_range;
    logic        cl_above_sp;
    logic        set_invalid;
    logic        set_ceiling_hit;

    // Writes are refused until the power-up load has finished
    assign run         = (state_reg == vsp_pkg::ST_RUN);
    assign wr_setpoint = run && WR_STROBE && (CMD_CODE == vsp_pkg::CMD_SETPOINT);
    assign wr_ceiling  = run && WR_STROBE && (CMD_CODE == vsp_pkg::CMD_CEILING);
    assign wr_save     = run && WR_STROBE && (CMD_CODE == vsp_pkg::CMD_SAVE_ALL);

    // Upper bits of the written word are dropped, not stored
    assign sp_word    = WR_DATA & vsp_pkg::SETPOINT_MASK;
    assign cl_word    = WR_DATA & vsp_pkg::CEILING_MASK;
    assign strap_word = {4'h0, strap_val};

    // Warning relation is strict on both sides
    assign sp_warn_bad = (sp_word >= OVERVOLTAGE_WARNING_THRESHOLD) ||
                         (sp_word <= UNDERVOLTAGE_WARNING_THRESHOLD);
    assign sp_range_bad     = (sp_word < rng.sp_min) || (sp_word > rng.sp_max);
    assign sp_below_floor   = (sp_word < SETPOINT_FLOOR);
    assign sp_above_ceiling = (sp_word > ceiling_reg);

    assign cl_in_range = (cl_word >= rng.cl_min) && (cl_word <= rng.cl_max);
    assign cl_above_sp = (cl_word >= setpoint_reg);

    // Init sequencing: settle the strap, then load defaults once
    always_comb
    begin
        state_next  = state_reg;
        settle_next = settle_reg;
        unique case (state_reg)
            vsp_pkg::ST_SETTLE:
            begin
                settle_next = settle_reg + 4'h1;
                if (settle_reg == vsp_pkg::SETTLE_CYCLES)
                begin
                    state_next = vsp_pkg::ST_LOAD;
                end
            end
            vsp_pkg::ST_LOAD:
            begin
                state_next = vsp_pkg::ST_RUN;
            end
            vsp_pkg::ST_RUN:
            begin
                state_next = vsp_pkg::ST_RUN;
            end
            default:
            begin
                state_next = vsp_pkg::ST_SETTLE;
            end
        endcase
    end

    // Setpoint and ceiling update
    always_comb
    begin
        setpoint_next   = setpoint_reg;
        ceiling_next    = ceiling_reg;
        set_invalid     = 1'b0;
        set_ceiling_hit = 1'b0;

        if (state_reg == vsp_pkg::ST_LOAD)
        begin
            // Ceiling takes the ratio default; strap then overrides restore
            ceiling_next = rng.cl_max;
            if (strap_sel)
            begin
                setpoint_next = (strap_word > rng.cl_max) ? rng.cl_max : strap_word;
            end
        end
        else if (!run && NVM_RESTORE)
        begin
            setpoint_next = NVM_RESTORE_DATA & vsp_pkg::SETPOINT_MASK;
        end
        else if (wr_setpoint)
        begin
            if (sp_warn_bad || sp_range_bad)
            begin
                set_invalid = 1'b1;
            end
            else if (sp_above_ceiling)
            begin
                setpoint_next   = ceiling_reg;
                set_ceiling_hit = 1'b1;
            end
            else if (sp_below_floor)
            begin
                setpoint_next = SETPOINT_FLOOR & vsp_pkg::SETPOINT_MASK;
            end
            else
            begin
                setpoint_next = sp_word;
            end
        end
        else if (wr_ceiling)
        begin
            if (cl_in_range && cl_above_sp)
            begin
                ceiling_next = cl_word;
            end
            else if (!cl_in_range && cl_above_sp)
            begin
                ceiling_next = rng.cl_max;
                set_invalid  = 1'b1;
            end
            else
            begin
                // Below setpoint: keep the old ceiling
                set_invalid = 1'b1;
            end
        end
    end

    // Sticky status flags; a new event wins over a clear in the same cycle
    always_comb
    begin
        cml_next  = (CLEAR_FLAGS ? 1'b0 : cml_reg) | set_invalid;
        ivd_next  = (CLEAR_FLAGS ? 1'b0 : ivd_reg) | set_invalid;
        oth_next  = (CLEAR_FLAGS ? 1'b0 : oth_reg) | set_ceiling_hit;
        vfw_next  = (CLEAR_FLAGS ? 1'b0 : vfw_reg) | set_ceiling_hit;
        chit_next = (CLEAR_FLAGS ? 1'b0 : chit_reg) | set_ceiling_hit;
    end

    // Read word and nonvolatile save handoff
    always_comb
    begin
        rd_valid_next = RD_STROBE;
        rd_data_next  = rd_data_reg;
        if (RD_STROBE)
        begin
            unique case (CMD_CODE)
                vsp_pkg::CMD_SETPOINT: rd_data_next = setpoint_reg & vsp_pkg::SETPOINT_MASK;
                vsp_pkg::CMD_CEILING:  rd_data_next = ceiling_reg & vsp_pkg::CEILING_MASK;
                default:               rd_data_next = vsp_pkg::READ_UNMAPPED;
            endcase
        end
        save_next    = wr_save;
        save_sp_next = save_sp_reg;
        save_cl_next = save_cl_reg;
        if (wr_save)
        begin
            save_sp_next = setpoint_reg;
            save_cl_next = ceiling_reg;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_reg  <= vsp_pkg::ST_SETTLE;
            settle_reg <= 4'h0;
        end
        else
        begin
            state_reg  <= state_next;
            settle_reg <= settle_next;
        end
    end

    // Ceiling starts at the unit-ratio maximum until the load cycle
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            setpoint_reg <= vsp_pkg::SETPOINT_RESET;
            ceiling_reg  <= vsp_pkg::SP_MAX_ONE;
        end
        else
        begin
            setpoint_reg <= setpoint_next;
            ceiling_reg  <= ceiling_next;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cml_reg  <= 1'b0;
            ivd_reg  <= 1'b0;
            oth_reg  <= 1'b0;
            vfw_reg  <= 1'b0;
            chit_reg <= 1'b0;
        end
        else
        begin
            cml_reg  <= cml_next;
            ivd_reg  <= ivd_next;
            oth_reg  <= oth_next;
            vfw_reg  <= vfw_next;
            chit_reg <= chit_next;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rd_data_reg  <= 16'h0000;
            rd_valid_reg <= 1'b0;
            save_reg     <= 1'b0;
            save_sp_reg  <= 16'h0000;
            save_cl_reg  <= 16'h0000;
        end
        else
        begin
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            save_reg     <= save_next;
            save_sp_reg  <= save_sp_next;
            save_cl_reg  <= save_cl_next;
        end
    end

    assign RD_DATA                           = rd_data_reg;
    assign RD_VALID                          = rd_valid_reg;
    assign NVM_SAVE                          = save_reg;
    assign NVM_SAVE_SETPOINT                 = save_sp_reg;
    assign NVM_SAVE_CEILING                  = save_cl_reg;
    assign COMMS_FAULT_FLAG                  = cml_reg;
    assign INVALID_DATA_FLAG                 = ivd_reg;
    assign MISCELLANEOUS_FAULT_FLAG          = oth_reg;
    assign OUTPUT_VOLTAGE_FAULT_WARNING_FLAG = vfw_reg;
    assign CEILING_HIT_WARNING               = chit_reg;
    assign SETPOINT                          = setpoint_reg;

    // Open-drain alert: pull low while any flag stands; bus level not needed here
    assign SMBALERT_O  = 1'b0;
    assign SMBALERT_OE = cml_reg | ivd_reg | oth_reg | vfw_reg | chit_reg;
endmodule

//--- verification/setpoint_monitor.sv
// Concurrent checks on the setpoint register bank ports
module setpoint_monitor
(
    input wire logic        CLOCK,
    input wire logic        RST_N,
    input wire logic [7:0]  CMD_CODE,
    input wire logic [15:0] WR_DATA,
    input wire logic        WR_STROBE,
    input wire logic        RD_STROBE,
    input wire logic [15:0] RD_DATA,
    input wire logic        RD_VALID,
    input wire logic [15:0] OVERVOLTAGE_WARNING_THRESHOLD,
    input wire logic        CLEAR_FLAGS,
    input wire logic        NVM_SAVE,
    input wire logic [15:0] NVM_SAVE_SETPOINT,
    input wire logic        COMMS_FAULT_FLAG,
    input wire logic        INVALID_DATA_FLAG,
    input wire logic        MISCELLANEOUS_FAULT_FLAG,
    input wire logic        OUTPUT_VOLTAGE_FAULT_WARNING_FLAG,
    input wire logic        CEILING_HIT_WARNING,
    input wire logic        SMBALERT_OE,
    input wire logic [15:0] SETPOINT
);
    timeunit 1ns;
    timeprecision 1ps;

    wire logic any_flag = COMMS_FAULT_FLAG | INVALID_DATA_FLAG | MISCELLANEOUS_FAULT_FLAG
                        | OUTPUT_VOLTAGE_FAULT_WARNING_FLAG | CEILING_HIT_WARNING;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    sequence save_req;
        WR_STROBE && CMD_CODE == vsp_pkg::CMD_SAVE_ALL;
    endsequence
    sequence sp_read;
        RD_STROBE && CMD_CODE == vsp_pkg::CMD_SETPOINT;
    endsequence
    sequence sp_over;
        WR_STROBE && CMD_CODE == vsp_pkg::CMD_SETPOINT
            && (WR_DATA & vsp_pkg::SETPOINT_MASK) >= OVERVOLTAGE_WARNING_THRESHOLD;
    endsequence

    chk_sp_read: assert property (sp_read |=> RD_VALID && RD_DATA == $past(SETPOINT))
        else $error("setpoint read data wrong");
    chk_unmapped_read: assert property (RD_STROBE && CMD_CODE != vsp_pkg::CMD_SETPOINT
        && CMD_CODE != vsp_pkg::CMD_CEILING |=> RD_VALID && RD_DATA == 16'h0000)
        else $error("unmapped read not zero");
    chk_alert_follows: assert property (SMBALERT_OE == any_flag)
        else $error("alert enable does not follow flags");
    chk_sp_upper: assert property (SETPOINT[15:12] == 4'h0)
        else $error("setpoint upper bits set");
    chk_sp_reset: assert property (disable iff (1'b0) !RST_N |-> SETPOINT == 16'h01e6)
        else $error("setpoint reset value wrong");
    chk_save_pulse: assert property (save_req |=> NVM_SAVE ##1 !NVM_SAVE)
        else $error("save pulse wrong");
    chk_save_value: assert property (NVM_SAVE |-> NVM_SAVE_SETPOINT == $past(SETPOINT))
        else $error("saved setpoint wrong");
    chk_warn_hold: assert property (sp_over |=> $stable(SETPOINT)
        && COMMS_FAULT_FLAG && INVALID_DATA_FLAG)
        else $error("warning violation not refused");
    chk_ceil_hit: assert property ($rose(CEILING_HIT_WARNING) |-> MISCELLANEOUS_FAULT_FLAG
        && OUTPUT_VOLTAGE_FAULT_WARNING_FLAG && $past(WR_STROBE))
        else $error("ceiling hit flags incomplete");
    chk_clear_flags: assert property (CLEAR_FLAGS && !WR_STROBE |=> !any_flag)
        else $error("flags not cleared");
endmodule

bind setpoint_limit_checker setpoint_monitor u_monitor
(
    .CLOCK(CLOCK), .RST_N(RST_N), .CMD_CODE(CMD_CODE), .WR_DATA(WR_DATA),
    .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .OVERVOLTAGE_WARNING_THRESHOLD(OVERVOLTAGE_WARNING_THRESHOLD),
    .CLEAR_FLAGS(CLEAR_FLAGS), .NVM_SAVE(NVM_SAVE), .NVM_SAVE_SETPOINT(NVM_SAVE_SETPOINT),
    .COMMS_FAULT_FLAG(COMMS_FAULT_FLAG), .INVALID_DATA_FLAG(INVALID_DATA_FLAG),
    .MISCELLANEOUS_FAULT_FLAG(MISCELLANEOUS_FAULT_FLAG),
    .OUTPUT_VOLTAGE_FAULT_WARNING_FLAG(OUTPUT_VOLTAGE_FAULT_WARNING_FLAG),
    .CEILING_HIT_WARNING(CEILING_HIT_WARNING), .SMBALERT_OE(SMBALERT_OE), .SETPOINT(SETPOINT)
);

//--- verification/host_model.sv
// Host word-access model driving the command port
module host_model
(
    input  wire logic        clk,
    output logic      [7:0]  cmd,
    output logic      [15:0] wdata,
    output logic             wstb,
    output logic             rstb
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cmd = 8'h00;
        wdata = 16'h0000;
        wstb = 1'b0;
        rstb = 1'b0;
    end

    // One whole word per strobe, held until the taking edge
    task automatic access(input logic [7:0] c, input logic [15:0] d, input logic rd);
        @(posedge clk);
        cmd <= c;
        wdata <= d;
        wstb <= !rd;
        rstb <= rd;
        @(posedge clk);
        wstb <= 1'b0;
        rstb <= 1'b0;
        // Released data must not keep showing the last word
        wdata <= ~d;
    endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the setpoint and ceiling register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst_n = 1'b1;
    wire  [7:0]  cmd;
    wire  [15:0] wdata;
    wire         wstb;
    wire         rstb;
    wire  [15:0] rdata;
    wire         rvalid;
    logic [15:0] floor_v = 16'h012c;
    logic [15:0] ov_v = 16'h02bc;
    logic [15:0] uv_v = 16'h0104;
    logic [2:0]  ratio = 3'h4;
    logic        strap_sel = 1'b0;
    logic [11:0] strap_val = 12'h000;
    logic        restore = 1'b0;
    logic [15:0] restore_d = 16'h0123;
    logic        clr = 1'b0;
    wire         save;
    wire  [15:0] save_sp;
    wire  [15:0] save_cl;
    wire  [4:0]  flg;
    wire         alert_o;
    wire         alert_oe;
    wire         alert_i = alert_oe ? 1'b0 : 1'b1;
    wire  [15:0] setpoint;
    logic [15:0] exp_q[$];
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    logic [31:0] lfsr = 32'h000180dc;
    logic [15:0] v;
    logic [15:0] mx[3] = '{16'h0300, 16'h0600, 16'h0c00};
    logic [15:0] mn[3] = '{16'h0100, 16'h0200, 16'h0400};
    logic [15:0] cm[3] = '{16'h011a, 16'h0234, 16'h0468};
    logic [2:0]  rt[3] = '{3'h4, 3'h2, 3'h1};

    always #2.5 clock = ~clock;

    host_model u_host (.clk(clock), .cmd(cmd), .wdata(wdata), .wstb(wstb), .rstb(rstb));

    setpoint_limit_checker u_dut
    (
        .CLOCK(clock), .RST_N(rst_n), .CMD_CODE(cmd), .WR_DATA(wdata),
        .WR_STROBE(wstb), .RD_STROBE(rstb), .RD_DATA(rdata), .RD_VALID(rvalid),
        .SETPOINT_FLOOR(floor_v), .OVERVOLTAGE_WARNING_THRESHOLD(ov_v),
        .UNDERVOLTAGE_WARNING_THRESHOLD(uv_v), .FEEDBACK_DIVIDER_RATIO(ratio),
        .STRAP_SELECT(strap_sel), .STRAP_SETPOINT_PIN(strap_val), .NVM_RESTORE(restore),
        .NVM_RESTORE_DATA(restore_d), .NVM_SAVE(save), .NVM_SAVE_SETPOINT(save_sp),
        .NVM_SAVE_CEILING(save_cl), .CLEAR_FLAGS(clr), .COMMS_FAULT_FLAG(flg[4]),
        .INVALID_DATA_FLAG(flg[3]), .MISCELLANEOUS_FAULT_FLAG(flg[2]),
        .OUTPUT_VOLTAGE_FAULT_WARNING_FLAG(flg[1]), .CEILING_HIT_WARNING(flg[0]),
        .SMBALERT_I(alert_i), .SMBALERT_O(alert_o), .SMBALERT_OE(alert_oe),
        .SETPOINT(setpoint)
    );

    function automatic logic [31:0] next_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        u_host.access(c, d, 1'b0);
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        exp_q.push_back(e);
        u_host.access(c, 16'h0000, 1'b1);
        @(posedge clock);
        // Let the watcher take the answer before anything else moves on
        wait (exp_q.size() == 0);
    endtask

    // Flags are sticky, so each check ends by clearing them
    task automatic flags(input logic [4:0] e);
        #1 check("flags", {11'h000, e}, {11'h000, flg});
        check("alert enable", {15'h0000, |e}, {15'h0000, alert_oe});
        check("alert drive", 16'h0000, {15'h0000, alert_o});
        @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
    endtask

    // Restore pulse lands before run, so a selected strap must override it
    task automatic do_reset(input logic [2:0] r, input logic [11:0] sv, input logic s);
        rst_n <= 1'b0;
        ratio <= r;
        strap_sel <= s;
        strap_val <= sv;
        repeat (10) @(posedge clock);
        #1 check("reset setpoint", 16'h01e6, setpoint);
        @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        restore <= 1'b1;
        @(posedge clock);
        restore <= 1'b0;
        repeat (12) @(posedge clock);
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            n_mismatch++;
            complete_run();
        end
        else if (rvalid === 1'b1)
            check("read data", exp_q.pop_front(), rdata);
    end

    initial
    begin
        do_reset(vsp_pkg::RATIO_ONE, 12'h258, 1'b1);
        check("strap setpoint", 16'h0258, setpoint);
        rd(vsp_pkg::CMD_CEILING, 16'h0300);
        rd(8'h99, 16'h0000);
        wr(vsp_pkg::CMD_SETPOINT, 16'hf200);
        rd(vsp_pkg::CMD_SETPOINT, 16'h0200);
        wr(vsp_pkg::CMD_SETPOINT, ov_v);
        flags(5'b11000);
        wr(vsp_pkg::CMD_SETPOINT, uv_v);
        flags(5'b11000);
        rd(vsp_pkg::CMD_SETPOINT, 16'h0200);
        wr(vsp_pkg::CMD_CEILING, 16'h0280);
        wr(vsp_pkg::CMD_SETPOINT, 16'h028a);
        flags(5'b00111);
        rd(vsp_pkg::CMD_SETPOINT, 16'h0280);
        wr(vsp_pkg::CMD_SETPOINT, 16'h0118);
        rd(vsp_pkg::CMD_SETPOINT, 16'h012c);
        wr(vsp_pkg::CMD_SAVE_ALL, 16'h0000);
        #1 check("save pulse", 16'h0001, {15'h0000, save});
        check("save setpoint", 16'h012c, save_sp);
        check("save ceiling", 16'h0280, save_cl);
        for (int i = 0; i < 6; i++)
        begin
            lfsr = next_lfsr(lfsr);
            v = 16'h012d + 16'(lfsr % 32'h0000018f);
            wr(vsp_pkg::CMD_SETPOINT, v);
            flags(v > 16'h0280 ? 5'b00111 : 5'b00000);
            rd(vsp_pkg::CMD_SETPOINT, v > 16'h0280 ? 16'h0280 : v);
        end
        wr(vsp_pkg::CMD_CEILING, 16'he400);
        flags(5'b11000);
        rd(vsp_pkg::CMD_CEILING, 16'h0300);
        wr(vsp_pkg::CMD_CEILING, 16'h0122);
        flags(5'b11000);
        rd(vsp_pkg::CMD_CEILING, 16'h0300);
        floor_v <= 16'h0000;
        ov_v <= 16'h0fff;
        uv_v <= 16'h0000;
        for (int i = 0; i < 3; i++)
        begin
            do_reset(rt[i], 12'hfff, 1'b1);
            check("strap clamp", mx[i], setpoint);
            rd(vsp_pkg::CMD_CEILING, mx[i]);
            wr(vsp_pkg::CMD_CEILING, mx[i] + 16'h0001);
            flags(5'b11000);
            wr(vsp_pkg::CMD_CEILING, mx[i] - 16'h0001);
            flags(5'b11000);
            rd(vsp_pkg::CMD_CEILING, mx[i]);
            wr(vsp_pkg::CMD_SETPOINT, mn[i] - 16'h0001);
            flags(5'b11000);
            wr(vsp_pkg::CMD_SETPOINT, mn[i]);
            flags(5'b00000);
            rd(vsp_pkg::CMD_SETPOINT, mn[i]);
            wr(vsp_pkg::CMD_CEILING, cm[i]);
            rd(vsp_pkg::CMD_CEILING, cm[i]);
        end
        // Strap not selected: the restored word must survive the load cycle
        do_reset(vsp_pkg::RATIO_ONE, 12'h000, 1'b0);
        check("restored setpoint", 16'h0123, setpoint);
        rd(vsp_pkg::CMD_CEILING, 16'h0300);
        complete_run();
    end
endmodule
